/* rtl/plrc_pkg.sv */
// Constants for the per-port loopback and reset control block.
// Assumes a classic Wishbone master and one 25 MHz clock.
`default_nettype none
package plrc_pkg;
  localparam int NPORT = 4;
  // Register numbers within a page
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_SPEC = 5'h10;
  localparam logic [4:0] REG_STAT = 5'h11;
  localparam logic [4:0] REG_EXTL = 5'h12;
  localparam logic [4:0] REG_MODE = 5'h14;
  localparam logic [4:0] REG_MACS = 5'h15;
  localparam logic [4:0] REG_PAGE = 5'h16;
  localparam logic [4:0] REG_GLB  = 5'h1A;
  localparam logic [4:0] REG_CHIP = 5'h1B;
  // Pages
  localparam logic [7:0] PG_CU   = 8'h00;
  localparam logic [7:0] PG_FIB  = 8'h01;
  localparam logic [7:0] PG_MAC  = 8'h02;
  localparam logic [7:0] PG_QSG  = 8'h04;
  localparam logic [7:0] PG_TEST = 8'h06;
  localparam logic [7:0] PG_MODE = 8'h12;
  // Bit positions
  localparam int B_RST   = 15;
  localparam int B_LOOP  = 14;
  localparam int B_SPD   = 13;
  localparam int B_ANEN  = 12;
  localparam int B_SPA   = 12;
  localparam int B_SPB   = 8;
  localparam int B_LLOOP = 14;
  localparam int B_RXPOL = 13;
  localparam int B_TXPOL = 12;
  localparam int B_SLOOP = 9;
  localparam int B_SYNC  = 5;
  localparam int B_LINK  = 10;
  localparam int B_EXTL  = 3;
  // Speed field codes and output codes
  localparam logic [2:0] SPF_10   = 3'h4;
  localparam logic [2:0] SPF_100  = 3'h5;
  localparam logic [2:0] SPF_1000 = 3'h6;
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // Copper transmit content during system loopback
  localparam logic [1:0] CM_NORM = 2'h0;
  localparam logic [1:0] CM_FLP  = 2'h1;
  localparam logic [1:0] CM_NLP  = 2'h2;
  localparam logic [1:0] CM_IDLE = 2'h3;
  // Reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [2:0] SPF_RST  = 3'h6;
  localparam logic       POL_RST  = 1'b1;
  // Reset durations in clock cycles
  localparam logic [7:0] SW_RST_CYC   = 8'h10;
  localparam logic [7:0] CHIP_RST_CYC = 8'h40;
endpackage : plrc_pkg
`default_nettype wire

/* rtl/plrc_top.sv */
// Per-port loopback, speed, status and reset control for four ports.
// Assumes a classic Wishbone master, one clock and frequency-locked symbols.
// Contract
// - Polarity bits zero invert receive/transmit
// - Page register selects register page
// - Per-port copies, registers 26/27 shared
// - Speed from field without link/loopback
// - Each port has independent speed
// - Sync status bit follows receiver lock
// - Link bit mirrors sync or negotiation
// - System loopback returns MAC data, drops link
// - Copper keeps sending pulses or idles
// - Loopback speed field encodes 10/100/1000
// - Serializer loopback returns raw symbols
// - Slow serializer loopback needs both bits
// - Fast serializer loopback by shared bit
// - Line loopback echoes line, drops MAC
// - Line loopback enables per media type
// - Gigabit stub loopback needs test bit
// - Chip reset bit equals hardware reset
// - Per-circuit resets touch only their circuit
// - Mode reset covers test and mode pages
// - Shared reset covers all four ports
// - Reset bits clear themselves
`timescale 1ns/1ps
`default_nettype none
module plrc_top
  import plrc_pkg::*;
#(
  parameter logic [7:0] SW_CYC   = SW_RST_CYC,
  parameter logic [7:0] CHIP_CYC = CHIP_RST_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hw_reset_pin_low,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [8:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Media and link status
  input  wire logic        syncRaw,
  input  wire logic [3:0]  mediaLink,
  input  wire logic [7:0]  mediaSpeed,
  input  wire logic [3:0]  anLinkOk,
  // Serializer symbols
  input  wire logic [9:0]  rxSym,
  input  wire logic [9:0]  txSymIn,
  output logic      [9:0]  txSym,
  // Path controls
  output logic             rxInvert,
  output logic             txInvert,
  output logic             serdes5gLoop,
  output logic      [3:0]  serdes1gLoop,
  output logic      [3:0]  sysLoop,
  output logic      [3:0]  lineLoopCu,
  output logic      [3:0]  lineLoopFib,
  output logic      [3:0]  lineLoopQsg,
  output logic      [3:0]  macTxDrop,
  output logic      [3:0]  extLoop1000,
  output logic      [7:0]  portSpeed,
  output logic      [7:0]  copperTxMode,
  // Circuit resets
  output logic             chipReset,
  output logic      [3:0]  cuReset,
  output logic      [3:0]  fibReset,
  output logic      [3:0]  qsgReset,
  output logic      [3:0]  modeReset,
  output logic             qsgAllReset
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] cntNext(input logic [7:0] cur, input logic go, input logic [7:0] len);
    cntNext = go ? len : ((cur != 8'h00) ? cur - 8'h01 : 8'h00);
  endfunction : cntNext

  function automatic logic [1:0] spdDecode(input logic [2:0] f);
    case (f)
      SPF_10:  spdDecode = SPD_10;
      SPF_100: spdDecode = SPD_100;
      default: spdDecode = SPD_1000;
    endcase
  endfunction : spdDecode

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, change counts when stages two and three agree
  logic [2:0] syncSh;
  logic [2:0] pinSh;
  logic       syncOk;
  logic       pinLow;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      syncSh <= 3'h0;
      pinSh  <= 3'h7;
      syncOk <= 1'b0;
      pinLow <= 1'b0;
    end
    else
    begin
      syncSh <= {syncSh[1:0], syncRaw};
      pinSh  <= {pinSh[1:0], hw_reset_pin_low};
      if (syncSh[1] == syncSh[2])
        syncOk <= syncSh[2];
      if (pinSh[1] == pinSh[2])
        pinLow <= ~pinSh[2];
    end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [7:0] chCnt;
  logic [7:0] qaCnt;
  logic [7:0] page [NPORT];
  wire        chipHold = chCnt != 8'h00;
  wire        req      = cyc_i & stb_i & ~ack_o & ~chipHold;
  wire        wr       = req & we_i;
  wire  [1:0] aPort    = adr_i[8:7];
  wire  [4:0] aReg     = adr_i[6:2];
  wire  [7:0] aPage    = page[aPort];
  wire [15:0] wMask    = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [15:0] wd       = dat_i[15:0] & wMask;
  wire        wrShared = wr & (aPage == PG_QSG);
  wire        wrGlb    = wrShared & (aReg == REG_GLB) & sel_i[1];
  wire        wrChip   = wrShared & (aReg == REG_CHIP) & sel_i[1];
  wire        qaHold   = qaCnt != 8'h00;

  function automatic logic hit(input int p, input logic [7:0] g, input logic [4:0] r);
    hit = wr & (aPort == p[1:0]) & (aPage == g) & (aReg == r);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // Shared control registers 26 and 27 of the link page
  logic rxPol;
  logic txPol;
  logic sLoop5;
  // chip reset from bit or pin
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      chCnt <= 8'h00;
      qaCnt <= 8'h00;
    end
    else
    begin
      chCnt <= cntNext(chCnt, wrChip & wd[B_RST] | pinLow, CHIP_CYC);
      qaCnt <= chipHold ? 8'h00 : cntNext(qaCnt, wrGlb & wd[B_RST], SW_CYC);
    end

  // shared bits, one copy for all ports
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rxPol  <= POL_RST;
      txPol  <= POL_RST;
      sLoop5 <= 1'b0;
    end
    else if (chipHold | qaHold)
    begin
      rxPol  <= POL_RST;
      txPol  <= POL_RST;
      sLoop5 <= 1'b0;
    end
    else if (wrGlb & ~wd[B_RST])
    begin
      rxPol  <= wd[B_RXPOL];
      txPol  <= wd[B_TXPOL];
      sLoop5 <= wd[B_SLOOP];
    end

  ////////////////////////////////////////////////////////////////////////
  // Per-port registers and reset counters
  logic [7:0] cuCnt [NPORT];
  logic [7:0] fiCnt [NPORT];
  logic [7:0] qsCnt [NPORT];
  logic [7:0] mdCnt [NPORT];
  logic       cuLoop [NPORT];
  logic       cuSpd  [NPORT];
  logic       cuAn   [NPORT];
  logic       fiLoop [NPORT];
  logic       fiSpA  [NPORT];
  logic       fiSpB  [NPORT];
  logic       qsLoop [NPORT];
  logic       qsAn   [NPORT];
  logic       qsLine [NPORT];
  logic       cuLine [NPORT];
  logic [2:0] spdF   [NPORT];
  logic       extL   [NPORT];

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    wire wCu  = hit(p, PG_CU, REG_CTRL);
    wire wFi  = hit(p, PG_FIB, REG_CTRL);
    wire wQs  = hit(p, PG_QSG, REG_CTRL);
    wire wMd  = hit(p, PG_MODE, REG_MODE) & sel_i[1];
    wire cuH  = chipHold | (cuCnt[p] != 8'h00);
    wire fiH  = chipHold | (fiCnt[p] != 8'h00);
    wire qsH  = chipHold | qaHold | (qsCnt[p] != 8'h00);
    wire mdH  = chipHold | (mdCnt[p] != 8'h00);

    // each circuit has its own counter
    always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
        cuCnt[p] <= 8'h00;
        fiCnt[p] <= 8'h00;
        qsCnt[p] <= 8'h00;
        mdCnt[p] <= 8'h00;
      end
      else
      begin
        cuCnt[p] <= chipHold ? 8'h00 : cntNext(cuCnt[p], wCu & sel_i[1] & wd[B_RST], SW_CYC);
        fiCnt[p] <= chipHold ? 8'h00 : cntNext(fiCnt[p], wFi & sel_i[1] & wd[B_RST], SW_CYC);
        qsCnt[p] <= chipHold ? 8'h00 : cntNext(qsCnt[p], wQs & sel_i[1] & wd[B_RST], SW_CYC);
        mdCnt[p] <= chipHold ? 8'h00 : cntNext(mdCnt[p], wMd & wd[B_RST], SW_CYC);
      end

    always_ff @(posedge clk or posedge rst)
      if (rst)
        page[p] <= PAGE_RST;
      else if (chipHold)
        page[p] <= PAGE_RST;
      else if (wr & (aPort == p[1:0]) & (aReg == REG_PAGE) & sel_i[0])
        page[p] <= wd[7:0];

    // copper circuit registers, pages 0 and 2
    always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
        cuLoop[p] <= 1'b0;
        cuSpd[p]  <= 1'b0;
        cuAn[p]   <= 1'b1;
        cuLine[p] <= 1'b0;
        spdF[p]   <= SPF_RST;
      end
      else if (cuH)
      begin
        cuLoop[p] <= 1'b0;
        cuSpd[p]  <= 1'b0;
        cuAn[p]   <= 1'b1;
        cuLine[p] <= 1'b0;
        spdF[p]   <= SPF_RST;
      end
      else
      begin
        if (wCu & sel_i[1])
        begin
          cuLoop[p] <= wd[B_LOOP];
          cuSpd[p]  <= wd[B_SPD];
          cuAn[p]   <= wd[B_ANEN];
        end
        if (hit(p, PG_MAC, REG_MACS) & sel_i[1])
          cuLine[p] <= wd[B_LLOOP];
        if (hit(p, PG_MAC, REG_MACS) & sel_i[0])
          spdF[p] <= wd[2:0];
      end

    // Fibre circuit registers, page 1
    always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
        fiLoop[p] <= 1'b0;
        fiSpA[p]  <= 1'b0;
        fiSpB[p]  <= 1'b0;
      end
      else if (fiH)
      begin
        fiLoop[p] <= 1'b0;
        fiSpA[p]  <= 1'b0;
        fiSpB[p]  <= 1'b0;
      end
      else
      begin
        if (wFi & sel_i[1])
          fiLoop[p] <= wd[B_LOOP];
        if (hit(p, PG_FIB, REG_SPEC) & sel_i[1])
          fiSpA[p] <= wd[B_SPA];
        if (hit(p, PG_FIB, REG_SPEC) & sel_i[1])
          fiSpB[p] <= wd[B_SPB];
      end

    // Link page per-port registers and test page bit
    always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
        qsLoop[p] <= 1'b0;
        qsAn[p]   <= 1'b1;
        qsLine[p] <= 1'b0;
      end
      else if (qsH)
      begin
        qsLoop[p] <= 1'b0;
        qsAn[p]   <= 1'b1;
        qsLine[p] <= 1'b0;
      end
      else
      begin
        if (wQs & sel_i[1])
        begin
          qsLoop[p] <= wd[B_LOOP];
          qsAn[p]   <= wd[B_ANEN];
        end
        if (hit(p, PG_QSG, REG_SPEC) & sel_i[1])
          qsLine[p] <= wd[B_LLOOP - 2];
      end

    always_ff @(posedge clk or posedge rst)
      if (rst)
        extL[p] <= 1'b0;
      else if (mdH)
        extL[p] <= 1'b0;
      else if (hit(p, PG_TEST, REG_EXTL) & sel_i[0])
        extL[p] <= wd[B_EXTL];

    wire sysL = cuLoop[p] | fiLoop[p] | qsLoop[p];
    wire lCu  = cuLine[p];
    // fibre line loopback needs bit 8 clear
    wire lFi  = fiSpA[p] & ~fiSpB[p];
    wire lQs  = qsLine[p];
    wire linkEff = mediaLink[p] & ~sysL;
    // field when no link or loopback
    wire [1:0] spdNx = linkEff ? mediaSpeed[2*p+:2] : spdDecode(spdF[p]);
    wire [1:0] cmNx = ~sysL ? CM_NORM : cuAn[p] ? CM_FLP : cuSpd[p] ? CM_IDLE : CM_NLP;

    always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
        sysLoop[p]          <= 1'b0;
        lineLoopCu[p]       <= 1'b0;
        lineLoopFib[p]      <= 1'b0;
        lineLoopQsg[p]      <= 1'b0;
        macTxDrop[p]        <= 1'b0;
        serdes1gLoop[p]     <= 1'b0;
        extLoop1000[p]      <= 1'b0;
        portSpeed[2*p+:2]   <= SPD_1000;
        copperTxMode[2*p+:2] <= CM_NORM;
        cuReset[p]          <= 1'b0;
        fibReset[p]         <= 1'b0;
        qsgReset[p]         <= 1'b0;
        modeReset[p]        <= 1'b0;
      end
      else
      begin
        sysLoop[p]          <= sysL;
        lineLoopCu[p]       <= lCu;
        lineLoopFib[p]      <= lFi;
        lineLoopQsg[p]      <= lQs;
        // MAC frames discarded in line loopback
        macTxDrop[p]        <= lCu | lFi | lQs;
        serdes1gLoop[p]     <= fiSpA[p] & fiSpB[p];
        extLoop1000[p]      <= extL[p];
        portSpeed[2*p+:2]   <= spdNx;
        copperTxMode[2*p+:2] <= cmNx;
        cuReset[p]          <= cuH;
        fibReset[p]         <= fiH;
        qsgReset[p]         <= qsH;
        modeReset[p]        <= mdH;
      end

    a_loop_speed: assert property (@(posedge clk) disable iff (rst)
      sysL && spdF[p] == SPF_100 |=> portSpeed[2*p+:2] == SPD_100)
      else $error("loopback speed wrong");
    a_link_speed: assert property (@(posedge clk) disable iff (rst)
      linkEff |=> portSpeed[2*p+:2] == $past(mediaSpeed[2*p+:2]))
      else $error("media speed not followed");
    a_slow_loop: assert property (@(posedge clk) disable iff (rst)
      serdes1gLoop[p] |-> $past(fiSpA[p]) && $past(fiSpB[p]))
      else $error("slow loopback without both bits");
    a_self_clear: assert property (@(posedge clk) disable iff (rst)
      $rose(cuCnt[p] != 8'h00) |-> ##[1:255] cuCnt[p] == 8'h00)
      else $error("copper reset never clears");
    a_flp_mode: assert property (@(posedge clk) disable iff (rst)
      sysL && cuAn[p] |=> copperTxMode[2*p+:2] == CM_FLP)
      else $error("no pulses in loopback");
    a_iso_reset: assert property (@(posedge clk) disable iff (rst)
      fiH && !cuH && !$past(cuH) |=> cuReset[p] == 1'b0)
      else $error("fibre reset touched copper");
  end : g_port

  ////////////////////////////////////////////////////////////////////////
  // Read selection
  // reset bits except the chip reset bit read one while busy
  function automatic logic [15:0] rdVal(input logic [1:0] p);
    logic [7:0] g;
    g = page[p];
    rdVal = 16'h0000;
    if (aReg == REG_PAGE)
      rdVal = {8'h00, g};
    else if (g == PG_CU && aReg == REG_CTRL)
      rdVal = {cuCnt[p] != 8'h00, cuLoop[p], cuSpd[p], cuAn[p], 12'h000};
    else if (g == PG_FIB && aReg == REG_CTRL)
      rdVal = {fiCnt[p] != 8'h00, fiLoop[p], 14'h0000};
    else if (g == PG_FIB && aReg == REG_SPEC)
      rdVal = {3'h0, fiSpA[p], 3'h0, fiSpB[p], 8'h00};
    else if (g == PG_MAC && aReg == REG_MACS)
      rdVal = {1'b0, cuLine[p], 11'h000, spdF[p]};
    else if (g == PG_QSG && aReg == REG_CTRL)
      rdVal = {qsCnt[p] != 8'h00, qsLoop[p], 1'b0, qsAn[p], 12'h000};
    else if (g == PG_QSG && aReg == REG_SPEC)
      rdVal = {3'h0, qsLine[p], 12'h000};
    else if (g == PG_QSG && aReg == REG_STAT)
      rdVal = {5'h00, qsAn[p] ? anLinkOk[p] : syncOk, 4'h0, syncOk, 5'h00};
    else if (g == PG_QSG && aReg == REG_GLB)
      rdVal = {qaHold, 1'b0, rxPol, txPol, 2'h0, sLoop5, 9'h000};
    else if (g == PG_QSG && aReg == REG_CHIP)
      rdVal = {chipHold, 15'h0000};
    else if (g == PG_TEST && aReg == REG_EXTL)
      rdVal = {12'h000, extL[p], 3'h0};
    else if (g == PG_MODE && aReg == REG_MODE)
      rdVal = {mdCnt[p] != 8'h00, 15'h0000};
  endfunction : rdVal

  wire [15:0] rdData = rdVal(aPort);

  ////////////////////////////////////////////////////////////////////////
  // Bus answer and shared outputs
  // no answer while chip reset runs
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= (req & ~we_i) ? {16'h0000, rdData} : 32'h00000000;
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rxInvert     <= 1'b0;
      txInvert     <= 1'b0;
      serdes5gLoop <= 1'b0;
      txSym        <= 10'h000;
      chipReset    <= 1'b1;
      qsgAllReset  <= 1'b0;
    end
    else
    begin
      rxInvert     <= ~rxPol;
      txInvert     <= ~txPol;
      serdes5gLoop <= sLoop5;
      txSym        <= sLoop5 ? rxSym : txSymIn;
      chipReset    <= chipHold;
      qsgAllReset  <= qaHold;
    end

  a_pol_inv: assert property (@(posedge clk) disable iff (rst)
    !rxPol |=> rxInvert)
    else $error("receive polarity not inverted");
  a_sym_loop: assert property (@(posedge clk) disable iff (rst)
    sLoop5 |=> txSym == $past(rxSym))
    else $error("raw symbol not looped");
  a_chip_mute: assert property (@(posedge clk) disable iff (rst)
    chipHold |=> !ack_o)
    else $error("ack during chip reset");
  a_all_reset: assert property (@(posedge clk) disable iff (rst)
    qaHold |=> rxPol && txPol && !sLoop5)
    else $error("shared reset ineffective");
  // link bit mirrors sync without negotiation
  a_link_bit: assert property (@(posedge clk) disable iff (rst)
    req && !we_i && aReg == REG_STAT && aPage == PG_QSG && !qsAn[aPort] |=> dat_o[B_LINK] == dat_o[B_SYNC])
    else $error("link bit differs from sync");
endmodule : plrc_top
`default_nettype wire

/* verif/plrc_mac_model.sv */
// MAC-side model: raw symbols and receiver lock for the system link.
// Assumes the one block clock; symbols are frequency locked to it.
`timescale 1ns/1ps
`default_nettype none
module plrc_mac_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Lock request from the bench
  input  wire logic       syncOn,
  // Link side
  output logic            syncRaw,
  output logic      [9:0] rxSym,
  output logic      [9:0] txSymIn
);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxSym   <= 10'h17C;
      txSymIn <= 10'h283;
    end
    else
    begin
      rxSym   <= {rxSym[8:0], rxSym[9] ^ rxSym[6]};
      txSymIn <= ~txSymIn ^ rxSym;
    end
  end
  assign syncRaw = syncOn;
endmodule : plrc_mac_model
`default_nettype wire

/* verif/plrc_top_test.sv */
// Self-checking bench for plrc_top over Wishbone on four ports.
// Assumes plrc_pkg and the MAC model; 25 MHz clock, reset 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module plrc_top_test;
  import plrc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, resetPinLow = 1'b1, syncOn = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [8:0]  adr = 9'h000;
  logic [3:0]  sel = 4'h0, mediaLink = 4'h0, anLinkOk = 4'h0;
  logic [31:0] dat = 32'h0, datO;
  logic [7:0]  mediaSpeed = 8'h00, lfsr = 8'h4D, expSpd, ms, spd, cuMode;
  logic        ack, syncRaw, rxInv, txInv, s5Loop, chipRst, qAllRst;
  logic [9:0]  rxSym, txSymIn, txSym, lastRx;
  logic [3:0]  s1Loop, sysLoop, llCu, llFib, llQsg, drop, ext, cuRst, fibRst, qsgRst, modeRst;
  logic [2:0]  f;
  logic [15:0] cuW [3] = '{16'h5000, 16'h4000, 16'h6000};
  logic [1:0]  cuExp [3] = '{CM_FLP, CM_NLP, CM_IDLE};
  int          p, n_mismatch = 0, checks_done = 0;

  plrc_mac_model plrc_mac_model_i (.clk(clk), .rst(rst), .syncOn(syncOn), .syncRaw(syncRaw), .rxSym(rxSym),
    .txSymIn(txSymIn));
  plrc_top #(.SW_CYC(8'h08), .CHIP_CYC(8'h10)) plrc_top_i (
    .clk(clk), .rst(rst), .hw_reset_pin_low(resetPinLow), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(datO), .ack_o(ack), .syncRaw(syncRaw), .mediaLink(mediaLink),
    .mediaSpeed(mediaSpeed), .anLinkOk(anLinkOk), .rxSym(rxSym), .txSymIn(txSymIn), .txSym(txSym),
    .rxInvert(rxInv), .txInvert(txInv), .serdes5gLoop(s5Loop), .serdes1gLoop(s1Loop), .sysLoop(sysLoop),
    .lineLoopCu(llCu), .lineLoopFib(llFib), .lineLoopQsg(llQsg), .macTxDrop(drop), .extLoop1000(ext),
    .portSpeed(spd), .copperTxMode(cuMode), .chipReset(chipRst), .cuReset(cuRst), .fibReset(fibRst),
    .qsgReset(qsgRst), .modeReset(modeRst), .qsgAllReset(qAllRst));

  initial
  begin
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nextRand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nextRand

  function automatic logic [1:0] fieldSpeed(input logic [2:0] c);
    return (c == SPF_10) ? SPD_10 : (c == SPF_100) ? SPD_100 : SPD_1000;
  endfunction : fieldSpeed

  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Classic cycle, held until ack is sampled high
  task automatic wb(input logic [1:0] pt, input logic [4:0] r, input logic w, input logic [15:0] d,
                    output logic [15:0] v);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {pt, r, 2'b00};
    sel <= 4'h3;
    dat <= {16'h0000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 300);
    if (n >= 300) n_mismatch++;
    v = datO[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [1:0] pt, input logic [4:0] r, input logic [15:0] d);
    logic [15:0] v;
    wb(pt, r, 1'b1, d, v);
  endtask : wr

  task automatic rdc(input logic [1:0] pt, input logic [4:0] r, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    wb(pt, r, 1'b0, 16'h0000, v);
    chk(v & m, e);
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(20);
    rst <= 1'b0;
    tick(2);
    rdc(2'h1, REG_PAGE, 16'hFFFF, 16'(PAGE_RST));
    chk(16'(spd), 16'h00AA);
    for (p = 0; p < 4; p++)
    begin
      lfsr = nextRand(lfsr);
      f = (p < 3) ? SPF_10 + 3'(p) : SPF_10 + 3'(lfsr % 3);
      expSpd[2*p +: 2] = fieldSpeed(f);
      ms[2*p +: 2] = 2'(lfsr % 3);
      wr(2'(p), REG_PAGE, 16'(PG_MAC));
      wr(2'(p), REG_MACS, 16'(f));
    end
    tick(3);
    chk(16'(spd), 16'(expSpd));
    mediaSpeed <= ms;
    mediaLink <= 4'hA;
    tick(3);
    chk(16'(spd), 16'({ms[7:6], expSpd[5:4], ms[3:2], expSpd[1:0]}));
    wr(2'h3, REG_PAGE, 16'(PG_QSG));
    wr(2'h3, REG_CTRL, 16'h5000);
    tick(3);
    chk(16'({spd[7:6], sysLoop[3]}), 16'({expSpd[7:6], 1'b1}));
    wr(2'h0, REG_PAGE, 16'(PG_CU));
    for (p = 0; p < 3; p++)
    begin
      wr(2'h0, REG_CTRL, cuW[p]);
      tick(3);
      chk(16'(cuMode[1:0]), 16'(cuExp[p]));
    end
    wr(2'h0, REG_CTRL, 16'h8000);
    tick(1);
    chk(16'({cuRst[0], fibRst[0]}), 16'h0002);
    wr(2'h0, REG_PAGE, 16'(PG_QSG));
    wr(2'h0, REG_GLB, 16'h0000);
    tick(2);
    chk(16'({rxInv, txInv}), 16'h0003);
    wr(2'h0, REG_GLB, 16'h2200);
    tick(2);
    chk(16'({rxInv, txInv, s5Loop}), 16'h0003);
    rdc(2'h3, REG_GLB, 16'hFFFF, 16'h2200);
    @(posedge clk);
    lastRx = rxSym;
    @(posedge clk);
    chk(16'(txSym), 16'(lastRx));
    mediaLink <= 4'hE; // link before line loop
    wr(2'h2, REG_MACS, 16'h4006);
    tick(2);
    chk(16'({llCu[2], drop[2]}), 16'h0003);
    wr(2'h2, REG_PAGE, 16'(PG_FIB));
    wr(2'h2, REG_SPEC, 16'h1100);
    tick(2);
    chk(16'({s1Loop[2], llFib[2]}), 16'h0002);
    wr(2'h2, REG_SPEC, 16'h1000);
    tick(2);
    chk(16'({s1Loop[2], llFib[2]}), 16'h0001);
    wr(2'h2, REG_CTRL, 16'h8000);
    tick(1);
    chk(16'({fibRst[2], cuRst[2]}), 16'h0002);
    wr(2'h2, REG_PAGE, 16'(PG_QSG));
    wr(2'h2, REG_SPEC, 16'h1000);
    tick(2);
    chk(16'(llQsg[2]), 16'h0001);
    wr(2'h1, REG_PAGE, 16'(PG_QSG));
    syncOn <= 1'b1;
    tick(6);
    rdc(2'h1, REG_STAT, 16'h0420, 16'h0020);
    anLinkOk <= 4'h2;
    tick(2);
    rdc(2'h1, REG_STAT, 16'h0420, 16'h0420);
    wr(2'h1, REG_CTRL, 16'h0000);
    anLinkOk <= 4'h0;
    tick(2);
    rdc(2'h1, REG_STAT, 16'h0420, 16'h0420);
    syncOn <= 1'b0;
    tick(6);
    rdc(2'h1, REG_STAT, 16'h0420, 16'h0000);
    wr(2'h1, REG_CTRL, 16'h8000);
    rdc(2'h1, REG_CTRL, 16'h8000, 16'h8000);
    chk(16'({qsgRst[1], cuRst[1], fibRst[1]}), 16'h0004);
    tick(12);
    rdc(2'h1, REG_CTRL, 16'h9000, 16'h1000);
    wr(2'h0, REG_PAGE, 16'(PG_MODE));
    wr(2'h0, REG_MODE, 16'h8000);
    tick(1);
    chk(16'({modeRst[0], cuRst[0]}), 16'h0002);
    rdc(2'h0, 5'h1F, 16'hFFFF, 16'h0000);
    wr(2'h3, REG_GLB, 16'h8000);
    tick(1);
    chk(16'({qAllRst, qsgRst}), 16'h001F);
    tick(12);
    wr(2'h3, REG_PAGE, 16'(PG_TEST)); // test bit before stub
    wr(2'h3, REG_EXTL, 16'h0008);
    tick(2);
    chk(16'(ext[3]), 16'h0001);
    mediaLink <= 4'h0;
    wr(2'h0, REG_PAGE, 16'(PG_QSG));
    wr(2'h0, REG_CHIP, 16'h8000);
    tick(1);
    chk(16'(chipRst), 16'h0001);
    rdc(2'h1, REG_PAGE, 16'hFFFF, 16'(PAGE_RST));
    chk(16'({spd, rxInv, txInv, s5Loop}), 16'h0550);
    resetPinLow <= 1'b0;
    tick(8);
    chk(16'(chipRst), 16'h0001);
    resetPinLow <= 1'b1;
    tick(30);
    chk(16'(chipRst), 16'h0000);
    conclude();
  end

  initial
  begin
    #(40 * 5000);
    n_mismatch++;
    conclude();
  end
endmodule : plrc_top_test
`default_nettype wire
